// File: hdl/adc_control_register_bank.sv
// Overview of operation
// - Triggered gate freezes amplifier gain
// - Gate triggers when pin level below threshold
// - Gate active only with level control channels
// - Bit 0 enables gate, default off
// - Threshold bits 4:2, 6 dB steps
// - Each select bit adds one input pair
// - One-hot codes pick pairs; default pair one
// - Buffer powerdown routes inputs to reference
// - Write to reset address resets bank
// - Software reset restores all register defaults; applied gain is not reset
// - Word is 7-bit address, 9-bit data
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_control_register_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control word from the serial interface
  input wire logic [15:0] ctrl_word,
  input wire logic ctrl_write,
  // Measured ADC level per channel in dB (left, right)
  input wire logic signed [7:0] adc_level_left_db,
  input wire logic signed [7:0] adc_level_right_db,
  // Gain requests from the level-control ramp (left, right)
  input wire logic [7:0] gain_req_left,
  input wire logic [7:0] gain_req_right,
  // Register contents
  output adc_ctrl_pkg::reg_word_t timeout_control_q,
  output adc_ctrl_pkg::reg_word_t audio_interface_format_q,
  output adc_ctrl_pkg::reg_word_t clocking_mode_control_q,
  output adc_ctrl_pkg::reg_word_t power_control_q,
  output adc_ctrl_pkg::reg_word_t left_gain_q,
  output adc_ctrl_pkg::reg_word_t right_gain_q,
  output adc_ctrl_pkg::reg_word_t level_control_one_q,
  output adc_ctrl_pkg::reg_word_t level_control_two_q,
  output adc_ctrl_pkg::reg_word_t level_control_three_q,
  output adc_ctrl_pkg::reg_word_t noise_gate_control_q,
  output adc_ctrl_pkg::reg_word_t limiter_control_q,
  output adc_ctrl_pkg::reg_word_t input_select_mute_q,
  // Mixer switches: pair enables and reference select
  output logic [3:0] pair_enable_q,
  output logic mid_supply_reference_q,
  // Gate state and effective amplifier gain
  output logic [1:0] gate_triggered_q,
  output logic [7:0] applied_gain_left_q,
  output logic [7:0] applied_gain_right_q,
  // Software reset pulse, high one cycle after the reset-address write
  output logic soft_reset_q
);
  import adc_ctrl_pkg::*;

  // Decoded word
  logic [6:0] addr;
  logic [8:0] data;
  assign addr = ctrl_word[`ADDR_HI:`ADDR_LO];
  assign data = ctrl_word[`DATA_HI:0];

  // Write strobes, one per address
  logic wr_timeout; // Timeout control
  logic wr_ifmt; // Interface format
  logic wr_clk; // Clocking mode
  logic wr_pwr; // Power control
  logic wr_lg; // Left gain
  logic wr_rg; // Right gain
  logic wr_lc1; // Level control one
  logic wr_lc2; // Level control two
  logic wr_lc3; // Level control three
  logic wr_gate; // Noise gate control
  logic wr_lim; // Limiter control
  logic wr_insel; // Input select and mute
  logic wr_srst; // Software reset, stores nothing
  assign wr_timeout = ctrl_write && (addr == `ADR_TIMEOUT);
  assign wr_ifmt = ctrl_write && (addr == `ADR_IFMT);
  assign wr_clk = ctrl_write && (addr == `ADR_CLKMODE);
  assign wr_pwr = ctrl_write && (addr == `ADR_POWER);
  assign wr_lg = ctrl_write && (addr == `ADR_LGAIN);
  assign wr_rg = ctrl_write && (addr == `ADR_RGAIN);
  assign wr_lc1 = ctrl_write && (addr == `ADR_LC1);
  assign wr_lc2 = ctrl_write && (addr == `ADR_LC2);
  assign wr_lc3 = ctrl_write && (addr == `ADR_LC3);
  assign wr_gate = ctrl_write && (addr == `ADR_GATE);
  assign wr_lim = ctrl_write && (addr == `ADR_LIMITER);
  assign wr_insel = ctrl_write && (addr == `ADR_INSEL);
  // Any data at the reset address triggers the reset
  assign wr_srst = ctrl_write && (addr == `ADR_SWRESET);

  // Register storage; software reset takes priority over a write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timeout_control_q <= `RST_TIMEOUT;
      audio_interface_format_q <= `RST_IFMT;
      clocking_mode_control_q <= `RST_CLKMODE;
      power_control_q <= `RST_POWER;
      left_gain_q <= `RST_GAIN;
      right_gain_q <= `RST_GAIN;
      level_control_one_q <= `RST_LC1;
      level_control_two_q <= `RST_LC2;
      level_control_three_q <= `RST_LC3;
      noise_gate_control_q <= `RST_GATE;
      limiter_control_q <= `RST_LIMITER;
      input_select_mute_q <= `RST_INSEL;
    end else if (wr_srst) begin
      // Return every register to its default
      timeout_control_q <= `RST_TIMEOUT;
      audio_interface_format_q <= `RST_IFMT;
      clocking_mode_control_q <= `RST_CLKMODE;
      power_control_q <= `RST_POWER;
      left_gain_q <= `RST_GAIN;
      right_gain_q <= `RST_GAIN;
      level_control_one_q <= `RST_LC1;
      level_control_two_q <= `RST_LC2;
      level_control_three_q <= `RST_LC3;
      noise_gate_control_q <= `RST_GATE;
      limiter_control_q <= `RST_LIMITER;
      input_select_mute_q <= `RST_INSEL;
    end else begin
      // Plain stores, all nine bits kept
      if (wr_timeout) timeout_control_q <= data;
      if (wr_ifmt) audio_interface_format_q <= data;
      if (wr_clk) clocking_mode_control_q <= data;
      if (wr_pwr) power_control_q <= data;
      if (wr_lg) left_gain_q <= data;
      if (wr_rg) right_gain_q <= data;
      if (wr_lc1) level_control_one_q <= data;
      if (wr_lc2) level_control_two_q <= data;
      if (wr_lc3) level_control_three_q <= data;
      if (wr_gate) noise_gate_control_q <= data;
      if (wr_lim) limiter_control_q <= data;
      if (wr_insel) input_select_mute_q <= data;
    end
  end

  // Software reset indicator
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= wr_srst;
    end
  end

  // Mixer routing: powerdown overrides the select field
  logic inpd;
  logic [3:0] insel;
  logic [3:0] pair_d;
  assign inpd = power_control_q[`PWR_INPD_BIT];
  assign insel = input_select_mute_q[`INSEL_HI:`INSEL_LO];
  assign pair_d = inpd ? 4'h0 : insel;

  // Registered mixer switches
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pair_enable_q <= `RST_PAIRS;
      mid_supply_reference_q <= 1'b0;
    end else begin
      pair_enable_q <= pair_d;
      mid_supply_reference_q <= inpd;
    end
  end

  // Gate controls
  chan_sel_t lc_sel;
  logic lc_on, gate_enable;
  logic [2:0] gate_threshold;
  logic signed [7:0] thresh_db;
  assign lc_sel = chan_sel_t'(level_control_one_q[`LC1_SEL_HI:`LC1_SEL_LO]);
  assign lc_on = level_control_two_q[`LC2_EN_BIT];
  assign gate_enable = noise_gate_control_q[`GATE_EN_BIT];
  assign gate_threshold = noise_gate_control_q[`GATE_TH_HI:`GATE_TH_LO];
  // -78 dBFS plus 6 dB per code step
  assign thresh_db = `GATE_BASE_DB + 8'(gate_threshold) * `GATE_STEP_DB;

  // Per-channel activity: bit 1 left, bit 0 right
  logic [1:0] chan_active;
  assign chan_active[1] = gate_enable && lc_on && (lc_sel == CH_LEFT || lc_sel == CH_BOTH);
  assign chan_active[0] = gate_enable && lc_on && (lc_sel == CH_RIGHT || lc_sel == CH_BOTH);

  // Level at the pin: ADC level less half the applied gain code (bits 7:1)
  logic signed [7:0] pin_db [2];
  assign pin_db[1] = adc_level_left_db - $signed({1'b0, applied_gain_left_q[7:1]});
  assign pin_db[0] = adc_level_right_db - $signed({1'b0, applied_gain_right_q[7:1]});

  // One comparator per channel
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_gate
      gate_channel u_gate_channel (
        .clock(clock),
        .reset_n(reset_n),
        .active(chan_active[g]),
        .threshold_db(thresh_db),
        .pin_level_db(pin_db[g]),
        .triggered_q(gate_triggered_q[g])
      );
    end
  endgenerate

  // Applied gain: follows request unless gate holds it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      applied_gain_left_q <= `RST_APPLIED_GAIN;
      applied_gain_right_q <= `RST_APPLIED_GAIN;
    end else begin
      if (!gate_triggered_q[1]) applied_gain_left_q <= gain_req_left;
      if (!gate_triggered_q[0]) applied_gain_right_q <= gain_req_right;
    end
  end

  // Checks
  // Left gain holds while its gate is triggered
  AST_GAIN_HELD: assert property (@(posedge clock) disable iff (!reset_n)
    gate_triggered_q[1] |=> $stable(applied_gain_left_q))
    else $error("left gain moved while gate triggered");

  // Right gain holds while its gate is triggered
  AST_GAIN_HELD_RIGHT: assert property (@(posedge clock) disable iff (!reset_n)
    gate_triggered_q[0] |=> $stable(applied_gain_right_q))
    else $error("right gain moved while gate triggered");

  // Open gate lets the gain follow its request
  AST_GAIN_FOLLOWS: assert property (@(posedge clock) disable iff (!reset_n)
    !gate_triggered_q[1] |=> applied_gain_left_q == $past(gain_req_left))
    else $error("left gain ignored its request");

  // No gate unless enable and level control are on
  AST_GATE_NEEDS_LC: assert property (@(posedge clock) disable iff (!reset_n)
    (!lc_on || !gate_enable) |=> gate_triggered_q == 2'b00)
    else $error("gate triggered without level control");

  // No gate when level control serves no channel
  AST_GATE_NO_CHAN: assert property (@(posedge clock) disable iff (!reset_n)
    lc_sel == CH_NONE |=> gate_triggered_q == 2'b00)
    else $error("gate triggered with no channel selected");

  // Right-only selection never gates the left channel
  AST_GATE_RIGHT_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
    lc_sel == CH_RIGHT |=> !gate_triggered_q[1])
    else $error("left gate triggered on right-only selection");

  // Left-only selection never gates the right channel
  AST_GATE_LEFT_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
    lc_sel == CH_LEFT |=> !gate_triggered_q[0])
    else $error("right gate triggered on left-only selection");

  // Right gate closes on a quiet active channel
  AST_GATE_TRIGGER: assert property (@(posedge clock) disable iff (!reset_n)
    (chan_active[0] && pin_db[0] < thresh_db) |=> gate_triggered_q[0])
    else $error("right gate failed to trigger");

  // Left gate closes on a quiet active channel
  AST_GATE_TRIGGER_LEFT: assert property (@(posedge clock) disable iff (!reset_n)
    (chan_active[1] && pin_db[1] < thresh_db) |=> gate_triggered_q[1])
    else $error("left gate failed to trigger");

  // Level at or above threshold leaves the gate open
  AST_GATE_OPEN: assert property (@(posedge clock) disable iff (!reset_n)
    pin_db[0] >= thresh_db |=> !gate_triggered_q[0])
    else $error("right gate triggered above threshold");

  // Disabled gate never triggers
  AST_GATE_DISABLED: assert property (@(posedge clock) disable iff (!reset_n)
    !gate_enable |=> gate_triggered_q == 2'b00)
    else $error("gate triggered while disabled");

  // Top threshold code
  AST_THRESH_RANGE: assert property (@(posedge clock) disable iff (!reset_n)
    gate_threshold == 3'h7 |-> thresh_db == -8'sd36)
    else $error("top threshold code wrong");

  // Bottom threshold code
  AST_THRESH_BASE: assert property (@(posedge clock) disable iff (!reset_n)
    gate_threshold == 3'h0 |-> thresh_db == -8'sd78)
    else $error("bottom threshold code wrong");

  // Mid-range threshold code, three steps up
  AST_THRESH_MID: assert property (@(posedge clock) disable iff (!reset_n)
    gate_threshold == 3'h3 |-> thresh_db == -8'sd60)
    else $error("mid threshold code wrong");

  // Pair switches follow the select field
  AST_PAIR_ROUTE: assert property (@(posedge clock) disable iff (!reset_n)
    !inpd |=> pair_enable_q == $past(insel))
    else $error("pair enables not following select");

  // Powerdown opens every pair and selects the reference
  AST_POWERDOWN: assert property (@(posedge clock) disable iff (!reset_n)
    inpd |=> pair_enable_q == 4'h0 && mid_supply_reference_q)
    else $error("powerdown did not select reference");

  // Reference released when buffer is powered
  AST_REF_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    !inpd |=> !mid_supply_reference_q)
    else $error("reference selected while buffer powered");

  // Reset-address write restores the select and limiter
  AST_SOFT_RESET: assert property (@(posedge clock) disable iff (!reset_n)
    wr_srst |=> input_select_mute_q == `RST_INSEL && limiter_control_q == `RST_LIMITER)
    else $error("software reset left a register changed");

  // Reset pulse follows a reset-address write
  AST_SRST_PULSE: assert property (@(posedge clock) disable iff (!reset_n)
    wr_srst |=> soft_reset_q)
    else $error("software reset pulse missing");

  // Reset pulse only after a reset-address write
  AST_SRST_SINGLE: assert property (@(posedge clock) disable iff (!reset_n)
    !wr_srst |=> !soft_reset_q)
    else $error("software reset pulse without a write");

  // Every other register returns to its default
  AST_SRST_DEFAULTS: assert property (@(posedge clock) disable iff (!reset_n)
    wr_srst |=> timeout_control_q == `RST_TIMEOUT && audio_interface_format_q == `RST_IFMT
      && clocking_mode_control_q == `RST_CLKMODE && power_control_q == `RST_POWER
      && left_gain_q == `RST_GAIN && right_gain_q == `RST_GAIN
      && level_control_one_q == `RST_LC1 && level_control_two_q == `RST_LC2
      && level_control_three_q == `RST_LC3 && noise_gate_control_q == `RST_GATE)
    else $error("software reset missed a default");

  // Gate register keeps the written data bits
  AST_WRITE_STORE: assert property (@(posedge clock) disable iff (!reset_n)
    wr_gate |=> noise_gate_control_q == $past(data))
    else $error("gate register write not stored");

  // Select register keeps the written data bits
  AST_INSEL_STORE: assert property (@(posedge clock) disable iff (!reset_n)
    wr_insel |=> input_select_mute_q == $past(data))
    else $error("select register write not stored");

  // Registers hold while no word is written
  AST_HOLD_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
    !ctrl_write |=> $stable(noise_gate_control_q) && $stable(input_select_mute_q) && $stable(power_control_q))
    else $error("register changed without a write");

  // Main scenarios
  COV_SRST: cover property (@(posedge clock) disable iff (!reset_n) wr_srst);
  COV_GATE: cover property (@(posedge clock) disable iff (!reset_n) gate_triggered_q == 2'b11);
  COV_MIX: cover property (@(posedge clock) disable iff (!reset_n) pair_enable_q == 4'h5);
  COV_LEFT_HELD: cover property (@(posedge clock) disable iff (!reset_n) gate_triggered_q == 2'b10);
  COV_REFERENCE: cover property (@(posedge clock) disable iff (!reset_n) mid_supply_reference_q);
endmodule : adc_control_register_bank
`default_nettype wire

// File: hdl/gate_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_regs.svh"
// One channel of the noise gate: compares level and registers the trigger state
module gate_channel (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Controls
  input wire logic active,
  input wire logic signed [7:0] threshold_db,
  // Input-pin level in dB (ADC level minus gain)
  input wire logic signed [7:0] pin_level_db,
  // Gate state
  output logic triggered_q
);
  logic trig_d;
  // Trigger when input-pin level below threshold
  assign trig_d = active && (pin_level_db < threshold_db);
  // Registered gate state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      triggered_q <= 1'b0;
    end else begin
      triggered_q <= trig_d;
    end
  end
endmodule : gate_channel
`default_nettype wire

// File: inc/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  // Channel selection of the level control
  typedef enum logic [1:0] {CH_NONE, CH_RIGHT, CH_LEFT, CH_BOTH} chan_sel_t;
  // Register word
  typedef logic [8:0] reg_word_t;
endpackage : adc_ctrl_pkg

// File: inc/adc_ctrl_regs.svh
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
// Control word layout
`define WORD_W 16
`define ADDR_HI 15
`define ADDR_LO 9
`define DATA_HI 8
`define DATA_W 9
`define ADDR_W 7
// Register addresses
`define ADR_TIMEOUT 7'h07
`define ADR_IFMT 7'h0B
`define ADR_CLKMODE 7'h0C
`define ADR_POWER 7'h0D
`define ADR_LGAIN 7'h0E
`define ADR_RGAIN 7'h0F
`define ADR_LC1 7'h10
`define ADR_LC2 7'h11
`define ADR_LC3 7'h12
`define ADR_GATE 7'h13
`define ADR_LIMITER 7'h14
`define ADR_INSEL 7'h15
`define ADR_SWRESET 7'h17
// Reset values
`define RST_TIMEOUT 9'h000
`define RST_IFMT 9'h022
`define RST_CLKMODE 9'h022
`define RST_POWER 9'h000
`define RST_GAIN 9'h0CF
`define RST_LC1 9'h07B
`define RST_LC2 9'h000
`define RST_LC3 9'h032
`define RST_GATE 9'h000
`define RST_LIMITER 9'h0A6
`define RST_INSEL 9'h001
`define RST_APPLIED_GAIN 8'hCF
`define RST_PAIRS 4'h0
// Field positions
`define GATE_EN_BIT 0
`define GATE_TH_HI 4
`define GATE_TH_LO 2
`define INSEL_HI 3
`define INSEL_LO 0
`define PWR_INPD_BIT 6
`define LC1_SEL_HI 8
`define LC1_SEL_LO 7
`define LC2_EN_BIT 8
`define GAIN_HI 7
// Gate threshold: -78 dBFS at code 0, 6 dB steps
`define GATE_BASE_DB 8'sh B2
`define GATE_STEP_DB 8'sh06
`endif

// File: test/adc_control_register_bank_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_control_register_bank_test;
  import adc_ctrl_pkg::*;
  logic clock, reset_n;
  logic [15:0] ctrl_word;
  logic ctrl_write;
  logic signed [7:0] lvl_l, lvl_r;
  logic [7:0] req_l, req_r;
  reg_word_t regs [12]; // Register contents in map order
  logic [3:0] pair_en;
  logic ref_sel, srst;
  logic [1:0] gate;
  logic [7:0] gain_l, gain_r;
  int n_fail, cmp_count;
  // Map order, defaults and non-default values with unused bits zero
  localparam logic [6:0] ADR [12] = '{`ADR_TIMEOUT, `ADR_IFMT, `ADR_CLKMODE, `ADR_POWER, `ADR_LGAIN,
    `ADR_RGAIN, `ADR_LC1, `ADR_LC2, `ADR_LC3, `ADR_GATE, `ADR_LIMITER, `ADR_INSEL};
  localparam reg_word_t DEF [12] = '{9'h000, 9'h022, 9'h022, 9'h000, 9'h0CF, 9'h0CF, 9'h07B, 9'h000,
    9'h032, 9'h000, 9'h0A6, 9'h001};
  localparam reg_word_t ALT [12] = '{9'h008, 9'h000, 9'h000, 9'h001, 9'h000, 9'h000, 9'h000, 9'h001,
    9'h000, 9'h001, 9'h000, 9'h000};
  host_writer u_host_writer (.clock(clock), .ctrl_word(ctrl_word), .ctrl_write(ctrl_write));
  adc_control_register_bank u_adc_control_register_bank (
    .clock(clock), .reset_n(reset_n), .ctrl_word(ctrl_word), .ctrl_write(ctrl_write),
    .adc_level_left_db(lvl_l), .adc_level_right_db(lvl_r), .gain_req_left(req_l), .gain_req_right(req_r),
    .timeout_control_q(regs[0]), .audio_interface_format_q(regs[1]), .clocking_mode_control_q(regs[2]),
    .power_control_q(regs[3]), .left_gain_q(regs[4]), .right_gain_q(regs[5]),
    .level_control_one_q(regs[6]), .level_control_two_q(regs[7]), .level_control_three_q(regs[8]),
    .noise_gate_control_q(regs[9]), .limiter_control_q(regs[10]), .input_select_mute_q(regs[11]),
    .pair_enable_q(pair_en), .mid_supply_reference_q(ref_sel), .gate_triggered_q(gate),
    .applied_gain_left_q(gain_l), .applied_gain_right_q(gain_r), .soft_reset_q(srst));
  // Compare one value
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Let n edges pass, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Defaults, writes, unmapped write, software reset with full data
  task automatic t_registers();
    for (int i = 0; i < 12; i++) check("reset value", regs[i], DEF[i]);
    for (int i = 0; i < 12; i++) u_host_writer.send(ADR[i], ALT[i]);
    u_host_writer.send(7'h16, 9'h000);
    for (int i = 0; i < 12; i++) check("written value", regs[i], ALT[i]);
    u_host_writer.send(`ADR_SWRESET, 9'h1FF);
    check("soft reset pulse", srst, 9'h001);
    for (int i = 0; i < 12; i++) check("soft reset value", regs[i], DEF[i]);
    tick(1);
    check("soft reset end", srst, 9'h000);
  endtask : t_registers
  // Pair selection, mixing and buffer powerdown
  task automatic t_mixer();
    for (int i = 0; i < 4; i++) begin
      u_host_writer.send(`ADR_INSEL, 9'(1 << i));
      tick(1);
      check("pair one-hot", pair_en, 9'(1 << i));
    end
    u_host_writer.send(`ADR_INSEL, 9'h005);
    tick(1);
    check("pair mix", pair_en, 9'h005);
    u_host_writer.send(`ADR_POWER, 9'h040);
    tick(1);
    check("reference on", ref_sel, 9'h001);
    check("pairs off", pair_en, 9'h000);
    u_host_writer.send(`ADR_POWER, 9'h000);
    tick(1);
    check("pairs back", pair_en, 9'h005);
  endtask : t_mixer
  // Set gate register and levels, then look at the gate
  task automatic gate_step(input logic [8:0] gr, input logic signed [7:0] l, r, input logic [1:0] exp);
    u_host_writer.send(`ADR_GATE, gr);
    lvl_l = l;
    lvl_r = r;
    tick(4);
    check("gate state", gate, exp);
  endtask : gate_step
  // Threshold ends, freeze, level-control dependence
  task automatic t_gate();
    u_host_writer.send(`ADR_LC1, 9'h1FB);
    u_host_writer.send(`ADR_LC2, 9'h100);
    gate_step(9'h01D, 8'sd60, 8'sd70, 2'b10);
    gate_step(9'h001, 8'sd20, 8'sd30, 2'b10);
    req_l = 8'h50;
    req_r = 8'h50;
    tick(4);
    check("left gain held", gain_l, 9'h0CF);
    check("right gain moves", gain_r, 9'h050);
    req_l = 8'hCF;
    req_r = 8'hCF;
    gate_step(9'h00D, 8'sd40, 8'sd45, 2'b10);
    gate_step(9'h000, 8'sd20, 8'sd20, 2'b00);
    u_host_writer.send(`ADR_LC1, 9'h0FB);
    gate_step(9'h001, 8'sd20, 8'sd20, 2'b01);
    u_host_writer.send(`ADR_LC2, 9'h000);
    gate_step(9'h001, 8'sd20, 8'sd20, 2'b00);
    u_host_writer.send(`ADR_LC1, 9'h17B);
    u_host_writer.send(`ADR_LC2, 9'h100);
    gate_step(9'h001, 8'sd20, 8'sd20, 2'b10);
    u_host_writer.send(`ADR_LC1, 9'h07B);
    gate_step(9'h001, 8'sd20, 8'sd20, 2'b00);
  endtask : t_gate
  // Clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Watchdog
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    lvl_l = 8'sd100;
    lvl_r = 8'sd100;
    req_l = 8'hCF;
    req_r = 8'hCF;
    n_fail = 0;
    cmp_count = 0;
    tick(16);
    reset_n = 1'b1;
    t_registers();
    t_mixer();
    t_gate();
    report_and_stop();
  end
endmodule : adc_control_register_bank_test
`default_nettype wire

// File: test/host_writer.sv
`timescale 1ns/10ps
`default_nettype none
// Host model: sends whole control words, one per write strobe
module host_writer (
  // Clock
  input wire logic clock,
  // Control word towards the bank
  output logic [15:0] ctrl_word,
  output logic ctrl_write
);
  // Idle bus shows junk, never a stale word
  initial begin
    ctrl_word = 16'hA5C3;
    ctrl_write = 1'b0;
  end
  // One write, held until the taking edge
  task automatic send(input logic [6:0] addr, input logic [8:0] data);
    @(posedge clock);
    #1;
    ctrl_word = {addr, data};
    ctrl_write = 1'b1;
    @(posedge clock);
    #1;
    ctrl_write = 1'b0;
    ctrl_word = ~ctrl_word;
  endtask : send
endmodule : host_writer
`default_nettype wire
